// ===== logic/fabric_queue_pkg.sv
package fabric_queue_pkg;
   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int PRIO_W = 2;
   localparam int DEST_W = 3;
   localparam int NDEST = 8;
   localparam int LEN_W = 9;
   localparam int NBC = 8;
   localparam int CAP_W = 8;
   localparam int THR_W = 16;
   localparam int OCC_W = 11;
   localparam int BCP_W = 3;
   localparam int BCC_W = 4;

   // ****************************************************************
   // Register byte addresses and fields
   // ****************************************************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_THRESH = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam int CTRL_CAP_EN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_TO_EN_BIT = 3;
   localparam int CTRL_IRQ_MASK_BIT = 4;
   localparam int CTRL_PR_DIS_BIT = 5;
   localparam int CTRL_CAP_LSB = 8;
   localparam int STATUS_TO_BIT = 0;
   localparam int STATUS_QCNT_LSB = 8;
   localparam int STATUS_MWQ_LSB = 16;
   localparam logic [THR_W-1:0] THRESH_RESET = 16'h0000;
   localparam logic [CAP_W-1:0] CAP_RESET = 8'h00;

   // ****************************************************************
   // Multicast sizes in bytes and packets
   // ****************************************************************
   localparam logic [OCC_W-1:0] MAX_PKT_BYTES = 11'h114;
   localparam logic [OCC_W-1:0] MWQ_BYTES = 11'h7a8;
   localparam int MWQ_PKTS = 245;
   localparam logic [LEN_W-1:0] BC_LIMIT = 9'h118;
   localparam logic [BCC_W-1:0] BC_MAX_PKTS = 4'h8;
   localparam logic [LEN_W-1:0] BEAT_BYTES = 9'h008;
   localparam logic [LEN_W-1:0] BEAT_MASK = 9'h007;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      MODE_ARRIVAL = 2'b00,
      MODE_PRIO_ONE = 2'b01,
      MODE_PRIO_TWO = 2'b10
   } arb_mode_t;

   typedef enum logic {
      FWD_IDLE = 1'b0,
      FWD_MOVE = 1'b1
   } fwd_state_t;

   typedef struct packed {
      logic [PRIO_W-1:0] prio;
      logic [DEST_W-1:0] dest;
   } fab_pkt_t;

   typedef struct packed {
      logic from_bcast;
      logic [PRIO_W-1:0] prio;
      logic [LEN_W-1:0] len;
      logic [NBC-1:0] vec;
   } mc_pkt_t;
endpackage : fabric_queue_pkg

// ===== logic/fabric_queue_control.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module fabric_queue_control #(
   parameter int QD = 8,
   parameter int NPORT = 8,
   parameter int MWQ_DEPTH = fabric_queue_pkg::MWQ_PKTS
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   // Ingress request queue
   input wire logic in_push_i,
   input wire fabric_queue_pkg::fab_pkt_t in_pkt_i,
   output logic in_ready_o,
   // Fabric destinations
   input wire logic [fabric_queue_pkg::NDEST-1:0] dest_ready_i,
   output logic fab_valid_o,
   output fabric_queue_pkg::fab_pkt_t fab_pkt_o,
   // Head timeout
   output logic head_timeout_irq_o,
   output logic port_report_o,
   // Multicast ingress
   input wire logic [NPORT-1:0] mc_req_i,
   input wire fabric_queue_pkg::mc_pkt_t [NPORT-1:0] mc_pkt_i,
   output logic [NPORT-1:0] mc_grant_o,
   output logic mwq_accept_o,
   // Broadcast egress
   input wire logic [fabric_queue_pkg::NBC-1:0] eg_ready_i,
   output logic [fabric_queue_pkg::NBC-1:0] eg_valid_o,
   output logic [fabric_queue_pkg::NBC-1:0][fabric_queue_pkg::LEN_W-1:0]
      eg_len_o,
   output logic [fabric_queue_pkg::NBC-1:0] bc_ready_o
);
   localparam int IW = $clog2(QD);
   localparam int CW = $clog2(QD + 1);
   localparam int PW = $clog2(NPORT);
   localparam int MW = $clog2(MWQ_DEPTH + 1);
   localparam int PRW = fabric_queue_pkg::PRIO_W;
   localparam int LW = fabric_queue_pkg::LEN_W;
   localparam int NB = fabric_queue_pkg::NBC;
   localparam int CAP_W_T = fabric_queue_pkg::CAP_W;

   function automatic logic [LW-1:0] round_beat(input logic [LW-1:0] len);
      round_beat = (len + fabric_queue_pkg::BEAT_MASK) &
         ~fabric_queue_pkg::BEAT_MASK;
   endfunction : round_beat

   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = (addr == fabric_queue_pkg::ADDR_CTRL) ||
         (addr == fabric_queue_pkg::ADDR_THRESH) ||
         (addr == fabric_queue_pkg::ADDR_STATUS);
   endfunction : is_mapped

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic cap_en;
   fabric_queue_pkg::arb_mode_t arb_mode;
   logic to_en;
   logic irq_mask;
   logic pr_dis;
   logic [CAP_W_T-1:0] delay_cap;
   logic [fabric_queue_pkg::THR_W-1:0] to_thresh;
   logic to_flag;
   logic drop;
   logic [CW-1:0] q_cnt;
   logic [MW-1:0] mwq_pkts;
   logic [31:0] rd;
   logic access;
   logic wr_ctrl;
   logic wr_thresh;
   logic wr_status;

   assign access = psel_i && penable_i && pready_o;
   assign wr_ctrl = access && pwrite_i &&
      (paddr_i == fabric_queue_pkg::ADDR_CTRL);
   assign wr_thresh = access && pwrite_i &&
      (paddr_i == fabric_queue_pkg::ADDR_THRESH);
   assign wr_status = access && pwrite_i &&
      (paddr_i == fabric_queue_pkg::ADDR_STATUS);

   always_comb begin
      rd = 32'h0000_0000;
      if (paddr_i == fabric_queue_pkg::ADDR_CTRL) begin
         rd[fabric_queue_pkg::CTRL_CAP_EN_BIT] = cap_en;
         rd[fabric_queue_pkg::CTRL_MODE_LSB +: 2] = arb_mode;
         rd[fabric_queue_pkg::CTRL_TO_EN_BIT] = to_en;
         rd[fabric_queue_pkg::CTRL_IRQ_MASK_BIT] = irq_mask;
         rd[fabric_queue_pkg::CTRL_PR_DIS_BIT] = pr_dis;
         rd[fabric_queue_pkg::CTRL_CAP_LSB +: CAP_W_T] = delay_cap;
      end else if (paddr_i == fabric_queue_pkg::ADDR_THRESH) begin
         rd[fabric_queue_pkg::THR_W-1:0] = to_thresh;
      end else if (paddr_i == fabric_queue_pkg::ADDR_STATUS) begin
         rd[fabric_queue_pkg::STATUS_TO_BIT] = to_flag;
         rd[fabric_queue_pkg::STATUS_QCNT_LSB +: 8] = 8'(q_cnt);
         rd[fabric_queue_pkg::STATUS_MWQ_LSB +: 8] = 8'(mwq_pkts);
      end
   end

   // Two-cycle access keeps pready and read data straight from flops
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i && penable_i && !pready_o;
         pslverr_o <= psel_i && penable_i && !pready_o &&
            !is_mapped(paddr_i);
         if (psel_i && penable_i && !pready_o) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         cap_en <= 1'b0;
         arb_mode <= fabric_queue_pkg::MODE_ARRIVAL;
         to_en <= 1'b0;
         irq_mask <= 1'b0;
         pr_dis <= 1'b0;
         delay_cap <= fabric_queue_pkg::CAP_RESET;
         to_thresh <= fabric_queue_pkg::THRESH_RESET;
      end else begin
         if (wr_ctrl) begin
            cap_en <= pwdata_i[fabric_queue_pkg::CTRL_CAP_EN_BIT];
            arb_mode <= fabric_queue_pkg::arb_mode_t'(
               pwdata_i[fabric_queue_pkg::CTRL_MODE_LSB +: 2]);
            to_en <= pwdata_i[fabric_queue_pkg::CTRL_TO_EN_BIT];
            irq_mask <= pwdata_i[fabric_queue_pkg::CTRL_IRQ_MASK_BIT];
            pr_dis <= pwdata_i[fabric_queue_pkg::CTRL_PR_DIS_BIT];
            delay_cap <= pwdata_i[fabric_queue_pkg::CTRL_CAP_LSB +:
               CAP_W_T];
         end
         if (wr_thresh) begin
            to_thresh <= pwdata_i[fabric_queue_pkg::THR_W-1:0];
         end
      end
   end

   // Timeout flag: a new timeout wins over a write-one clear
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         to_flag <= 1'b0;
         head_timeout_irq_o <= 1'b0;
         port_report_o <= 1'b0;
      end else begin
         to_flag <= (drop && to_en) || (to_flag && !(wr_status &&
            pwdata_i[fabric_queue_pkg::STATUS_TO_BIT]));
         head_timeout_irq_o <= to_flag && irq_mask;
         port_report_o <= drop && to_en && !pr_dis;
      end
   end

   // ****************************************************************
   // Ingress request queue
   // ****************************************************************
   logic [PRW-1:0] q_prio [QD];
   logic [fabric_queue_pkg::DEST_W-1:0] q_dest [QD];
   logic [CAP_W_T-1:0] q_ctr [QD];
   logic [PRW-1:0] next_prio [QD];
   logic [fabric_queue_pkg::DEST_W-1:0] next_dest [QD];
   logic [CAP_W_T-1:0] next_ctr [QD];
   logic [CW-1:0] next_cnt;
   logic [QD-1:0] elig;
   logic [QD-1:0] valid;
   logic sel_ok;
   logic [IW-1:0] sel_idx;
   logic send;
   logic remove;
   logic push_ok;
   logic arb_warm;
   logic [fabric_queue_pkg::THR_W-1:0] head_timer;

   // Eligible: destination ready and not barred by a zero counter ahead
   always_comb begin
      logic allow;
      allow = 1'b1;
      for (int j = 0; j < QD; j++) begin
         valid[j] = (j < int'(q_cnt));
         allow = 1'b1;
         for (int i = 0; i < QD; i++) begin
            if (i < j && cap_en && q_ctr[i] == '0 &&
               q_prio[j] <= q_prio[i]) begin
               allow = 1'b0;
            end
         end
         elig[j] = valid[j] && dest_ready_i[q_dest[j]] && allow;
      end
   end

   always_comb begin
      logic [PRW-1:0] top;
      top = '0;
      sel_ok = 1'b0;
      sel_idx = '0;
      case (arb_mode)
         fabric_queue_pkg::MODE_PRIO_ONE: begin
            // Later hits override: highest priority, nearest the head
            for (int p = 0; p < (1 << PRW); p++) begin
               for (int i = QD - 1; i >= 0; i--) begin
                  if (elig[i] && q_prio[i] == PRW'(p)) begin
                     sel_ok = 1'b1;
                     sel_idx = IW'(i);
                  end
               end
            end
         end
         fabric_queue_pkg::MODE_PRIO_TWO: begin
            // A blocked top-priority packet stalls all lower ones
            for (int i = 0; i < QD; i++) begin
               if (valid[i] && q_prio[i] > top) begin
                  top = q_prio[i];
               end
            end
            // Nearest ready packet of the top priority, if any
            for (int i = QD - 1; i >= 0; i--) begin
               if (elig[i] && q_prio[i] == top) begin
                  sel_ok = 1'b1;
                  sel_idx = IW'(i);
               end
            end
         end
         default: begin
            for (int i = QD - 1; i >= 0; i--) begin
               if (elig[i]) begin
                  sel_ok = 1'b1;
                  sel_idx = IW'(i);
               end
            end
         end
      endcase
   end

   // First candidate after idle spends one cycle in arbitration
   assign send = sel_ok && arb_warm;
   assign drop = !send && q_cnt != '0 && to_thresh != '0 &&
      head_timer >= to_thresh;
   assign remove = send || drop;
   assign push_ok = in_push_i && in_ready_o;

   always_comb begin
      logic [IW-1:0] rm;
      logic [CW-1:0] pos;
      rm = send ? sel_idx : '0;
      pos = q_cnt - CW'(remove);
      for (int i = 0; i < QD; i++) begin
         next_prio[i] = q_prio[i];
         next_dest[i] = q_dest[i];
         next_ctr[i] = q_ctr[i];
         if (cap_en && send && i < int'(sel_idx) && q_ctr[i] != '0 &&
            q_prio[i] >= q_prio[sel_idx]) begin
            next_ctr[i] = q_ctr[i] - CAP_W_T'(1);
         end
      end
      for (int i = 0; i < QD - 1; i++) begin
         if (remove && i >= int'(rm)) begin
            next_prio[i] = q_prio[i + 1];
            next_dest[i] = q_dest[i + 1];
            next_ctr[i] = q_ctr[i + 1];
         end
      end
      if (push_ok) begin
         next_prio[IW'(pos)] = in_pkt_i.prio;
         next_dest[IW'(pos)] = in_pkt_i.dest;
         next_ctr[IW'(pos)] = delay_cap;
      end
      next_cnt = pos + CW'(push_ok);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         q_cnt <= '0;
         in_ready_o <= 1'b0;
         for (int i = 0; i < QD; i++) begin
            q_prio[i] <= '0;
            q_dest[i] <= '0;
            q_ctr[i] <= '0;
         end
      end else begin
         q_cnt <= next_cnt;
         in_ready_o <= next_cnt < CW'(QD);
         for (int i = 0; i < QD; i++) begin
            q_prio[i] <= next_prio[i];
            q_dest[i] <= next_dest[i];
            q_ctr[i] <= next_ctr[i];
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         arb_warm <= 1'b0;
         fab_valid_o <= 1'b0;
         fab_pkt_o <= '0;
      end else begin
         arb_warm <= (q_cnt != '0) && (sel_ok || arb_warm);
         fab_valid_o <= send;
         fab_pkt_o <= {q_prio[sel_idx], q_dest[sel_idx]};
      end
   end

   // Head wait timer, restarted whenever the head can have changed
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         head_timer <= '0;
      end else if (q_cnt == '0 || remove) begin
         head_timer <= '0;
      end else if (head_timer != '1) begin
         head_timer <= head_timer + 1'b1;
      end
   end

   // ****************************************************************
   // Multicast work queue
   // ****************************************************************
   logic [LW-1:0] m_len [MWQ_DEPTH];
   logic [NB-1:0] m_vec [MWQ_DEPTH];
   logic [MW-1:0] m_wp;
   logic [MW-1:0] m_rp;
   logic [fabric_queue_pkg::OCC_W-1:0] m_occ;
   logic [fabric_queue_pkg::OCC_W-1:0] next_occ;
   logic [PW-1:0] rr;
   logic [PW-1:0] win;
   logic win_ok;
   logic [NPORT-1:0] mc_elig;
   fabric_queue_pkg::fwd_state_t fwd_state;
   logic [LW-1:0] fwd_left;
   logic [NB-1:0] fwd_vec;
   logic [NB-1:0] fit;
   logic [NB-1:0] bc_rdy;
   logic start;
   logic move_ok;
   logic last;
   logic [LW-1:0] head_rnd;

   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         mc_elig[p] = mc_req_i[p] && !mc_pkt_i[p].from_bcast &&
            !mc_grant_o[p] && mwq_accept_o &&
            mwq_pkts < MW'(MWQ_DEPTH);
      end
   end

   always_comb begin
      int idx;
      logic [PRW-1:0] best;
      idx = 0;
      best = '0;
      win_ok = 1'b0;
      win = '0;
      for (int k = 1; k <= NPORT; k++) begin
         idx = (int'(rr) + k) % NPORT;
         if (mc_elig[idx] && (!win_ok || mc_pkt_i[idx].prio > best)) begin
            win_ok = 1'b1;
            win = PW'(idx);
            best = mc_pkt_i[idx].prio;
         end
      end
   end

   assign head_rnd = round_beat(m_len[m_rp]);
   assign start = fwd_state == fabric_queue_pkg::FWD_IDLE &&
      mwq_pkts != '0 && (&fit);
   assign move_ok = fwd_state == fabric_queue_pkg::FWD_MOVE &&
      (&(bc_rdy | ~fwd_vec));
   assign last = fwd_left <= fabric_queue_pkg::BEAT_BYTES;
   assign next_occ = m_occ +
      (win_ok ? fabric_queue_pkg::OCC_W'(round_beat(mc_pkt_i[win].len)) :
      '0) - (move_ok ? fabric_queue_pkg::OCC_W'(fabric_queue_pkg::BEAT_BYTES)
      : '0);

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         m_wp <= '0;
         m_rp <= '0;
         m_occ <= '0;
         mwq_pkts <= '0;
         rr <= '0;
         mc_grant_o <= '0;
         mwq_accept_o <= 1'b0;
      end else begin
         m_occ <= next_occ;
         mwq_accept_o <= (fabric_queue_pkg::MWQ_BYTES - next_occ) >=
            fabric_queue_pkg::MAX_PKT_BYTES;
         mc_grant_o <= win_ok ? (NPORT'(1) << win) : '0;
         mwq_pkts <= mwq_pkts + MW'(win_ok) - MW'(move_ok && last);
         if (win_ok) begin
            rr <= win;
            m_len[m_wp] <= mc_pkt_i[win].len;
            m_vec[m_wp] <= mc_pkt_i[win].vec;
            m_wp <= (m_wp == MW'(MWQ_DEPTH - 1)) ? '0 : m_wp + 1'b1;
         end
         if (move_ok && last) begin
            m_rp <= (m_rp == MW'(MWQ_DEPTH - 1)) ? '0 : m_rp + 1'b1;
         end
      end
   end

   // Head leaves once the forwarder is idle and every buffer in its vector has room: strict FIFO
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         fwd_state <= fabric_queue_pkg::FWD_IDLE;
         fwd_left <= '0;
         fwd_vec <= '0;
      end else begin
         case (fwd_state)
            fabric_queue_pkg::FWD_IDLE: begin
               if (start) begin
                  fwd_state <= fabric_queue_pkg::FWD_MOVE;
                  fwd_left <= head_rnd;
                  fwd_vec <= m_vec[m_rp];
               end
            end
            fabric_queue_pkg::FWD_MOVE: begin
               if (move_ok) begin
                  fwd_left <= fwd_left - fabric_queue_pkg::BEAT_BYTES;
                  if (last) begin
                     fwd_state <= fabric_queue_pkg::FWD_IDLE;
                  end
               end
            end
            default: fwd_state <= fabric_queue_pkg::FWD_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Broadcast buffers
   // ****************************************************************
   for (genvar v = 0; v < NB; v++) begin : g_bc
      logic [LW-1:0] bl [fabric_queue_pkg::BC_MAX_PKTS];
      logic [fabric_queue_pkg::BCP_W-1:0] bwp;
      logic [fabric_queue_pkg::BCP_W-1:0] brp;
      logic [fabric_queue_pkg::BCC_W-1:0] cnt;
      logic [fabric_queue_pkg::BCC_W-1:0] done;
      logic [LW-1:0] resv;
      logic [LW-1:0] fill;
      logic [LW-1:0] pop_rnd;
      logic take;
      logic beat;
      logic pop;

      assign take = start && m_vec[m_rp][v];
      assign beat = move_ok && fwd_vec[v];
      // Egress sees only complete packets
      assign pop = eg_ready_i[v] && done != '0;
      assign pop_rnd = round_beat(bl[brp]);
      assign fit[v] = !m_vec[m_rp][v] ||
         (cnt < fabric_queue_pkg::BC_MAX_PKTS &&
         ({1'b0, resv} + {1'b0, head_rnd}) <=
         {1'b0, fabric_queue_pkg::BC_LIMIT});
      assign bc_rdy[v] = (fabric_queue_pkg::BC_LIMIT - fill) >=
         fabric_queue_pkg::BEAT_BYTES;

      always_ff @(posedge clk_sys_i or negedge rst_n) begin
         if (!rst_n) begin
            bwp <= '0;
            brp <= '0;
            cnt <= '0;
            done <= '0;
            resv <= '0;
            fill <= '0;
            eg_valid_o[v] <= 1'b0;
            eg_len_o[v] <= '0;
            bc_ready_o[v] <= 1'b0;
         end else begin
            cnt <= cnt + fabric_queue_pkg::BCC_W'(take) -
               fabric_queue_pkg::BCC_W'(pop);
            done <= done + fabric_queue_pkg::BCC_W'(beat && last) -
               fabric_queue_pkg::BCC_W'(pop);
            resv <= resv + (take ? head_rnd : '0) - (pop ? pop_rnd : '0);
            fill <= fill + (beat ? fabric_queue_pkg::BEAT_BYTES : '0) -
               (pop ? pop_rnd : '0);
            eg_valid_o[v] <= pop;
            eg_len_o[v] <= bl[brp];
            bc_ready_o[v] <= bc_rdy[v];
            if (take) begin
               bl[bwp] <= m_len[m_rp];
               bwp <= bwp + 1'b1;
            end
            if (pop) begin
               brp <= brp + 1'b1;
            end
         end
      end
   end
endmodule : fabric_queue_control

// ===== tb/fabric_queue_checker.sv
`timescale 1ns/1ps
module fabric_queue_checker #(
   parameter int NPORT = 8
) (
   // Watched ports
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [7:0] dest_ready_i,
   input wire logic fab_valid_o,
   input wire fabric_queue_pkg::fab_pkt_t fab_pkt_o,
   input wire logic [NPORT-1:0] mc_req_i,
   input wire fabric_queue_pkg::mc_pkt_t [NPORT-1:0] mc_pkt_i,
   input wire logic [NPORT-1:0] mc_grant_o,
   input wire logic mwq_accept_o,
   input wire logic [7:0] eg_ready_i,
   input wire logic [7:0] eg_valid_o,
   input wire logic [7:0][8:0] eg_len_o
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   logic [NPORT-1:0] ok_req;
   logic [7:0] rdy_q;
   // Buffer copies are never legal multicast sources
   always_comb
      for (int i = 0; i < NPORT; i++)
         ok_req[i] = mc_req_i[i] & !mc_pkt_i[i].from_bcast;
   always_ff @(posedge clk_sys_i) rdy_q <= dest_ready_i;
   sequence s_grant; |mc_grant_o; endsequence
   property p_onehot; $onehot0(mc_grant_o); endproperty
   a_onehot: assert property (p_onehot) else $error("two grants");
   property p_gap; s_grant |=> (mc_grant_o & $past(mc_grant_o)) == '0;
   endproperty
   a_gap: assert property (p_gap) else $error("repeat grant");
   property p_accept; s_grant |-> $past(mwq_accept_o); endproperty
   a_accept: assert property (p_accept) else $error("full");
   property p_src; s_grant |-> (mc_grant_o & ~$past(ok_req)) == '0;
   endproperty
   a_src: assert property (p_src) else $error("bad source");
   property p_eg; |eg_valid_o |-> (eg_valid_o & ~$past(eg_ready_i)) == 0;
   endproperty
   a_eg: assert property (p_eg) else $error("egress stall");
   property p_len; eg_valid_o[0] |-> eg_len_o[0] inside {[9'h001:9'h114]};
   endproperty
   a_len: assert property (p_len) else $error("egress length");
   property p_fab; fab_valid_o |-> rdy_q[fab_pkt_o.dest]; endproperty
   a_fab: assert property (p_fab) else $error("blocked send");
   property p_err; pslverr_o |-> pready_o; endproperty
   a_err: assert property (p_err) else $error("lone slverr");
endmodule : fabric_queue_checker
bind fabric_queue_control fabric_queue_checker #(.NPORT(NPORT)) u_chk (.*);

// ===== tb/fabric_queue_partner.sv
`timescale 1ns/1ps
module fabric_queue_partner (
   // Bench side
   input wire logic clk_sys_i,
   input wire logic [7:0] block_i,
   // Toward the block
   output logic [7:0] dest_ready_o,
   output logic [7:0] eg_ready_o
);
   logic slow = 1'h0;
   // Egress ports busy every other cycle, as a loaded port would be
   always @(posedge clk_sys_i) slow <= !slow;
   assign dest_ready_o = ~block_i;
   assign eg_ready_o = {8{slow}};
endmodule : fabric_queue_partner

// ===== tb/fabric_queue_control_tb_top.sv
`timescale 1ns/1ps
module fabric_queue_control_tb_top;
   // ****
   // Bench
   // ****
   logic clk_sys_i = 1'h0, arst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
   logic pwrite_i = 1'h0, in_push_i = 1'h0, pready_o, pslverr_o, in_ready_o;
   logic fab_valid_o, head_timeout_irq_o, port_report_o, mwq_accept_o;
   logic [11:0] paddr_i = 12'h0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, q, seq, gs;
   fabric_queue_pkg::fab_pkt_t in_pkt_i = '0, fab_pkt_o;
   logic [7:0] dest_ready_i, eg_ready_i, eg_valid_o, bc_ready_o, block = 8'h0;
   logic [7:0] mc_req_i = 8'h0, mc_grant_o;
   fabric_queue_pkg::mc_pkt_t [7:0] mc_pkt_i = '0;
   logic [7:0][8:0] eg_len_o;
   int err_total = 0, compares = 0, nrep = 0, elen = 0;
   fabric_queue_control u_dut (.*);
   fabric_queue_partner u_far (.clk_sys_i, .block_i(block),
      .dest_ready_o(dest_ready_i), .eg_ready_o(eg_ready_i));
   initial forever #4 clk_sys_i = !clk_sys_i;
   always @(negedge clk_sys_i) begin
      if (fab_valid_o === 1'h1) seq <= {seq[27:0], 1'h1, fab_pkt_o.dest};
      if (port_report_o === 1'h1) nrep++;
      if (eg_valid_o[0] === 1'h1) elen += eg_len_o[0];
   end
   task automatic chk(input logic [31:0] got, exp, input string n);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
      @(posedge clk_sys_i);
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'h1;
      do @(posedge clk_sys_i); while (pready_o !== 1'h1);
      q = prdata_o;
      chk(pslverr_o, {31'h0, a > 12'h008}, "slverr");
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask : apb
   task automatic push(input fabric_queue_pkg::fab_pkt_t p);
      @(posedge clk_sys_i);
      in_push_i <= 1'h1;
      in_pkt_i <= p;
      @(posedge clk_sys_i);
      in_push_i <= 1'h0;
   endtask : push
   task automatic t_regs;
      apb(1'h0, 12'h000, 32'h0);
      chk(q, 32'h0, "ctrl");
      for (int m = 0; m < 3; m++) begin
         apb(1'h1, 12'h000, 32'(m) << 1);
         apb(1'h0, 12'h000, 32'h0);
         chk(q, 32'(m) << 1, "mode");
      end
      apb(1'h0, 12'h00c, 32'h0);
   endtask : t_regs
   // Cap of one: a single equal-priority overtake, then only higher
   task automatic t_cap(input logic en, input logic [31:0] exp);
      apb(1'h1, 12'h000, {16'h0, 8'h01, 7'h0, en});
      block <= 8'h01;
      seq <= 32'h0;
      push(5'h00);
      push(5'h01);
      push(5'h02);
      push(5'h1b);
      repeat (12) @(posedge clk_sys_i);
      block <= 8'h00;
      repeat (12) @(posedge clk_sys_i);
      chk(seq, exp, "order");
   endtask : t_cap
   // Strict two: a blocked top-priority packet holds back lower ones
   task automatic t_strict;
      apb(1'h1, 12'h000, 32'h4);
      block <= 8'h08;
      seq <= 32'h0;
      push(5'h1b);
      push(5'h01);
      repeat (12) @(posedge clk_sys_i);
      chk(seq, 32'h0, "stalled");
      block <= 8'h00;
      repeat (12) @(posedge clk_sys_i);
      chk(seq, 32'hb9, "strict order");
      chk(in_ready_o, 1'h1, "in ready");
   endtask : t_strict
   task automatic t_timeout;
      apb(1'h1, 12'h004, 32'h10);
      apb(1'h1, 12'h000, 32'h18);
      block <= 8'h01;
      seq <= 32'h0;
      push(5'h00);
      repeat (40) @(posedge clk_sys_i);
      chk(nrep, 1, "report");
      chk(head_timeout_irq_o, 1'h1, "irq");
      apb(1'h1, 12'h000, 32'h38);
      push(5'h00);
      repeat (40) @(posedge clk_sys_i);
      chk(nrep, 1, "muted");
      chk(seq, 32'h0, "dropped");
      apb(1'h1, 12'h004, 32'h0);
      block <= 8'h00;
   endtask : t_timeout
   task automatic t_mc;
      logic [7:0] g;
      mc_pkt_i[0] <= {1'h0, 2'h0, 9'h008, 8'h01};
      mc_pkt_i[1] <= {1'h0, 2'h3, 9'h008, 8'h01};
      mc_pkt_i[2] <= {1'h1, 2'h3, 9'h008, 8'h01};
      mc_req_i <= 8'h07;
      gs = 32'h0;
      repeat (40) begin
         @(posedge clk_sys_i);
         g = mc_grant_o;
         if (g != 8'h0) gs = {gs[27:0], g[3:0]};
         mc_req_i <= mc_req_i & ~g;
      end
      chk(gs, 32'h21, "grants");
      chk(elen, 16, "egress bytes");
      chk(mwq_accept_o, 1'h1, "accept");
      chk(bc_ready_o, 8'hff, "bc ready");
   endtask : t_mc
   task automatic report_and_stop;
      $display("mismatches %0d, compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20) @(posedge clk_sys_i);
      arst_n_i <= 1'h1;
      repeat (5) @(posedge clk_sys_i);
      t_regs();
      t_cap(1'h0, 32'h9ab8);
      t_cap(1'h1, 32'h9b8a);
      t_strict();
      t_timeout();
      t_mc();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      report_and_stop();
   end
endmodule : fabric_queue_control_tb_top
